// file: inc/acp_pkg.sv
// Shared constants, types and helpers for the address-capable I/O port
package acp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int MODE_W = 3;
  localparam int IDX_W  = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION  = 16'hFEBA;
  localparam logic [IDX_W-1:0] IDX_PIN_STATE_VIEW = 16'hFF5A;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_DATA    = 16'hFF6A;
  localparam logic [IDX_W-1:0] IDX_PULLUP_CONTROL = 16'hFF71;
  localparam logic [IDX_W-1:0] IDX_STANDBY_CTRL   = 16'hFF80;
  localparam logic [IDX_W-1:0] IDX_MODE_STATUS    = 16'hFF81;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fields
  localparam logic [PORT_W-1:0] RST_PIN_DIRECTION  = 8'h00;
  localparam logic [PORT_W-1:0] RST_OUTPUT_DATA    = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULLUP_CONTROL = 8'h00;
  localparam logic              RST_STANDBY_OE     = 1'h0;
  localparam logic [MODE_W-1:0] RST_MODE           = 3'h0;
  localparam logic [PORT_W-1:0] DIRECTION_READBACK = 8'hFF;
  localparam int                STANDBY_OE_POS     = 0;
  localparam logic [2:0]        MODE_CAPTURE_CYC   = 3'h4;
  localparam logic [1:0]        RESP_OKAY          = 2'h0;
  localparam logic [1:0]        RESP_SLVERR        = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    FN_INPUT    = 2'b00,
    FN_GPIO_OUT = 2'b01,
    FN_ADDR_OUT = 2'b10
  } acp_func_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HELD = 2'b01,
    WR_RESP = 2'b10
  } acp_wr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin function from mode and direction bit
  function automatic acp_func_t acp_pin_func(input logic [MODE_W-1:0] mode,
                                             input logic              dirBit);
    case (mode)
      3'h1, 3'h4, 3'h5: acp_pin_func = FN_ADDR_OUT;
      3'h2, 3'h6:       acp_pin_func = dirBit ? FN_ADDR_OUT : FN_INPUT;
      3'h3, 3'h7:       acp_pin_func = dirBit ? FN_GPIO_OUT : FN_INPUT;
      default:          acp_pin_func = FN_INPUT;
    endcase
  endfunction

  // Pull-ups are usable only where a pin can be an input
  function automatic logic acp_pull_mode(input logic [MODE_W-1:0] mode);
    case (mode)
      3'h2, 3'h3, 3'h6, 3'h7: acp_pull_mode = 1'b1;
      default:                acp_pull_mode = 1'b0;
    endcase
  endfunction

  // Word index of a byte address
  function automatic logic [IDX_W-1:0] acp_index(input logic [ADDR_W-1:0] addr);
    acp_index = addr[ADDR_W-1:2];
  endfunction

endpackage

// file: inc/acp_drive_if.sv
// Carrier between port control logic and the pin driver
`timescale 1ns/1ns
interface acp_drive_if;
  import acp_pkg::*;
  logic [PORT_W-1:0] addrSel;
  logic [PORT_W-1:0] gpioSel;
  logic [PORT_W-1:0] addrBits;
  logic [PORT_W-1:0] dataBits;
  logic [PORT_W-1:0] pullReq;
  logic              holdAddr;
  logic              floatAddr;
  logic              floatAll;

  modport ctrl (output addrSel, gpioSel, addrBits, dataBits, pullReq,
                output holdAddr, floatAddr, floatAll);
  modport drv  (input addrSel, gpioSel, addrBits, dataBits, pullReq,
                input holdAddr, floatAddr, floatAll);
endinterface

// file: src/acp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module acp_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] stable
);
  import acp_pkg::*;

  logic [W-1:0] stageA;
  logic [W-1:0] stageB;
  logic [W-1:0] stageC;

  // Chain; stageA feeds only stageB to keep metastability contained
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stageA <= '0;
      stageB <= '0;
      stageC <= '0;
    end else begin
      stageA <= raw;
      stageB <= stageA;
      stageC <= stageB;
    end
  end

  // A bit moves only once the last two stages agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stable <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stageB[i] == stageC[i]) begin
          stable[i] <= stageC[i];
        end
      end
    end
  end
endmodule

// file: src/acp_pin_drive.sv
// Registered pin driver: level, enable and pull-up per pin
`timescale 1ns/1ns
module acp_pin_drive (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  acp_drive_if.drv                   ctl,
  output logic [acp_pkg::PORT_W-1:0] pinOut,
  output logic [acp_pkg::PORT_W-1:0] pinOe_n,
  output logic [acp_pkg::PORT_W-1:0] pullupOn
);
  import acp_pkg::*;

  // Per-pin drive; held address keeps last value while standby freezes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut   <= '0;
      pinOe_n  <= '1;
      pullupOn <= '0;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (ctl.floatAll) begin
          pinOe_n[i] <= 1'b1;
        end else if (ctl.addrSel[i]) begin
          pinOe_n[i] <= ctl.floatAddr;
          if (!ctl.holdAddr) begin
            pinOut[i] <= ctl.addrBits[i];
          end
        end else if (ctl.gpioSel[i]) begin
          pinOe_n[i] <= 1'b0;
          pinOut[i]  <= ctl.dataBits[i];
        end else begin
          pinOe_n[i] <= 1'b1;
        end
      end
      pullupOn <= ctl.floatAll ? '0 : ctl.pullReq;
    end
  end
endmodule

// file: src/acp_port.sv
// Address-capable 8-bit I/O port with AXI4-Lite register access
// Notes on behaviour
// - Eight-bit direction register, write only; reads return an undefined value.
// - Direction clears on power-on and hardware standby, kept otherwise.
// - Modes 1, 4, 5: every pin is an address output.
// - Modes 2, 6: direction 1 gives address output, 0 gives input.
// - Modes 3, 7: direction 1 gives data-register output, 0 gives input.
// - Eight-bit data register, read/write, cleared like direction, kept otherwise.
// - Pin-state view is read only; writes are ignored.
// - View returns data bit where direction is 1, pin level where 0.
// - View follows pins after clearing; frozen during software standby unless hardware standby is also on.
// - Eight-bit pull-up control register, cleared like direction, kept otherwise.
// - Pull-up on only in modes 2,3,6,7 with direction 0, control 1.
// - Pull-ups off after power-on and hardware standby, else retained.
// - In software standby address pins hold or float per standby enable bit.
`timescale 1ns/1ns
module acp_port (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // AXI4-Lite slave
  input  wire logic [acp_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [acp_pkg::DATA_W-1:0]   wdata,
  input  wire logic [acp_pkg::DATA_W/8-1:0] wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [acp_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [acp_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // Chip state
  input  wire logic [acp_pkg::MODE_W-1:0]   modePins,
  input  wire logic                         hwStandbyPin,
  input  wire logic                         swStandby,
  input  wire logic [acp_pkg::PORT_W-1:0]   extAddr,
  // Port pins
  input  wire logic [acp_pkg::PORT_W-1:0]   pinIn,
  output logic [acp_pkg::PORT_W-1:0]        pinOut,
  output logic [acp_pkg::PORT_W-1:0]        pinOe_n,
  output logic [acp_pkg::PORT_W-1:0]        pullupOn
);
  import acp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PORT_W-1:0] pinDirection;
  logic [PORT_W-1:0] outputData;
  logic [PORT_W-1:0] pullupControl;
  logic              standbyOutputEnable;
  logic [PORT_W-1:0] pinStateView;
  logic [MODE_W-1:0] opMode;
  logic              modeCaught;
  logic [2:0]        modeCount;
  logic [PORT_W-1:0] pinLevel;
  logic [MODE_W-1:0] modeLevel;
  logic              hwStandby;
  logic              swStandbyQ;

  acp_wr_state_t     wrState;
  acp_wr_state_t     next_wrState;
  logic              awHeld;
  logic              wHeld;
  logic [IDX_W-1:0]  wrIdx;
  logic [PORT_W-1:0] wrByte;
  logic              wrLane;
  logic              doWrite;
  logic              next_awHeld;
  logic              next_wHeld;
  logic [DATA_W-1:0] rdWord;
  logic              rdHit;

  acp_func_t         pinFunc [PORT_W];
  acp_drive_if       drive ();

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins, mode straps and hardware standby
  acp_pin_sync #(.W(PORT_W)) u_syncPins (
    .clk    (clk),
    .arst_n (arst_n),
    .raw    (pinIn),
    .stable (pinLevel)
  );

  acp_pin_sync #(.W(MODE_W)) u_syncMode (
    .clk    (clk),
    .arst_n (arst_n),
    .raw    (modePins),
    .stable (modeLevel)
  );

  acp_pin_sync #(.W(1)) u_syncStby (
    .clk    (clk),
    .arst_n (arst_n),
    .raw    (hwStandbyPin),
    .stable (hwStandby)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode strap, caught once after reset release
  // Waiting a few cycles lets the synchroniser settle before the capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opMode     <= RST_MODE;
      modeCaught <= 1'b0;
      modeCount  <= '0;
    end else if (!modeCaught) begin
      if (modeCount == MODE_CAPTURE_CYC) begin
        opMode     <= modeLevel;
        modeCaught <= 1'b1;
      end else begin
        modeCount <= modeCount + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel handshake; address and data accepted in either order
  assign doWrite = awHeld && wHeld && (wrState != WR_RESP);

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
    end
    if (bvalid && bready) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
    end
  end

  always_comb begin
    case (wrState)
      WR_IDLE: next_wrState = (next_awHeld || next_wHeld) ? WR_HELD : WR_IDLE;
      WR_HELD: next_wrState = doWrite ? WR_RESP : WR_HELD;
      WR_RESP: next_wrState = (bvalid && bready) ? WR_IDLE : WR_RESP;
      default: next_wrState = WR_IDLE;
    endcase
  end

  // Ready flags are registered so the bus outputs come from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrState <= WR_IDLE;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      wrIdx   <= '0;
      wrByte  <= '0;
      wrLane  <= 1'b0;
    end else begin
      wrState <= next_wrState;
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awready <= ~next_awHeld;
      wready  <= ~next_wHeld;
      if (awvalid && awready) begin
        wrIdx <= acp_index(awaddr);
      end
      if (wvalid && wready) begin
        wrByte <= wdata[PORT_W-1:0];
        wrLane <= wstrb[0];
      end
    end
  end

  // Write response; unmapped indices answer with a slave error
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      case (wrIdx)
        IDX_PIN_DIRECTION, IDX_PIN_STATE_VIEW, IDX_OUTPUT_DATA,
        IDX_PULLUP_CONTROL, IDX_STANDBY_CTRL, IDX_MODE_STATUS: bresp <= RESP_OKAY;
        default: bresp <= RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port registers; only power-on reset and hardware standby clear them
  // direction write only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinDirection <= RST_PIN_DIRECTION;
    end else if (hwStandby) begin
      pinDirection <= RST_PIN_DIRECTION;
    end else if (doWrite && wrLane && wrIdx == IDX_PIN_DIRECTION) begin
      pinDirection <= wrByte;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outputData <= RST_OUTPUT_DATA;
    end else if (hwStandby) begin
      outputData <= RST_OUTPUT_DATA;
    end else if (doWrite && wrLane && wrIdx == IDX_OUTPUT_DATA) begin
      outputData <= wrByte;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pullupControl <= RST_PULLUP_CONTROL;
    end else if (hwStandby) begin
      pullupControl <= RST_PULLUP_CONTROL;
    end else if (doWrite && wrLane && wrIdx == IDX_PULLUP_CONTROL) begin
      pullupControl <= wrByte;
    end
  end

  // Standby output-enable bit; survives hardware standby like the rest of
  // the system control block, only power-on reset clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standbyOutputEnable <= RST_STANDBY_OE;
    end else if (doWrite && wrLane && wrIdx == IDX_STANDBY_CTRL) begin
      standbyOutputEnable <= wrByte[STANDBY_OE_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin-state view, sampled every cycle and frozen in software standby unless hardware standby is also on
  // data where output, pin where input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinStateView <= '0;
      swStandbyQ   <= 1'b0;
    end else begin
      swStandbyQ <= swStandby;
      if (!swStandby || hwStandby) begin
        pinStateView <= (pinDirection & outputData) | (~pinDirection & pinLevel);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; direction reads back a fixed junk value
  // view is read only
  always_comb begin
    rdWord = '0;
    rdHit  = 1'b1;
    case (acp_index(araddr))
      IDX_PIN_DIRECTION:  rdWord[PORT_W-1:0] = DIRECTION_READBACK;
      IDX_PIN_STATE_VIEW: rdWord[PORT_W-1:0] = pinStateView;
      IDX_OUTPUT_DATA:    rdWord[PORT_W-1:0] = outputData;
      IDX_PULLUP_CONTROL: rdWord[PORT_W-1:0] = pullupControl;
      IDX_STANDBY_CTRL:   rdWord[STANDBY_OE_POS] = standbyOutputEnable;
      IDX_MODE_STATUS:    rdWord[MODE_W-1:0] = opMode;
      default:            rdHit = 1'b0;
    endcase
  end

  // One read at a time; address taken only while no data is pending
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdWord;
      rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function selection per mode and direction
  // address in modes 1, 4, 5
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pinFunc[i]         = acp_pin_func(opMode, pinDirection[i]);
      drive.addrSel[i]   = (pinFunc[i] == FN_ADDR_OUT);
      drive.gpioSel[i]   = (pinFunc[i] == FN_GPIO_OUT);
      drive.pullReq[i]   = acp_pull_mode(opMode) && !pinDirection[i]
                           && pullupControl[i];
    end
  end

  // address pins follow the internal address
  assign drive.addrBits = extAddr;
  assign drive.dataBits = outputData;

  // hold or float address pins in software standby
  assign drive.holdAddr  = swStandbyQ && swStandby;
  assign drive.floatAddr = swStandby && !standbyOutputEnable;
  // Nothing drives until the mode is known, avoiding a brief address burst
  assign drive.floatAll  = hwStandby || !modeCaught;

  acp_pin_drive u_drive (
    .clk      (clk),
    .arst_n   (arst_n),
    .ctl      (drive),
    .pinOut   (pinOut),
    .pinOe_n  (pinOe_n),
    .pullupOn (pullupOn)
  );
endmodule

// file: dv/acp_port_sva.sv
// Concurrent checks on the port's bus handshakes and pin outputs
`timescale 1ns/1ns
module acp_port_sva (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic [1:0]                 bresp,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [acp_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0]                 rresp,
  input wire logic                       rvalid,
  input wire logic                       rready,
  input wire logic                       hwStandbyPin,
  input wire logic [acp_pkg::PORT_W-1:0] pinOe_n,
  input wire logic [acp_pkg::PORT_W-1:0] pullupOn
);
  import acp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not two edges after handshake");
  a_resp_held:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed while stalled");
  a_write_blocked:
    assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted before response taken");

  // Read channel
  a_read_answer:
    assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one edge after address");
  a_read_held:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed while stalled");
  a_read_upper:
    assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_refused_zero:
    assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read carries data");

  ////////////////////////////////////////////////////////////////////////////
  // Pins: a pull-up never fights the port's own driver
  a_pull_input:
    assert property ((pullupOn & ~pinOe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  a_hw_float:
    assert property (hwStandbyPin [*8] |-> pinOe_n == 8'hFF && pullupOn == 8'h00)
    else $error("pins not released in hardware standby");
  a_reset_float:
    assert property ($rose(arst_n) |-> pinOe_n == 8'hFF && pullupOn == 8'h00)
    else $error("pins driven straight after reset");
endmodule

bind acp_port acp_port_sva u_sva (.*);

// file: dv/acp_pin_model.sv
// Far side of the pins: outside drivers, pull-ups and floating lines
`timescale 1ns/1ns
module acp_pin_model (
  input  wire logic                       clk,
  input  wire logic [acp_pkg::PORT_W-1:0] pinOut,
  input  wire logic [acp_pkg::PORT_W-1:0] pinOe_n,
  input  wire logic [acp_pkg::PORT_W-1:0] pullupOn,
  input  wire logic [acp_pkg::PORT_W-1:0] extDrv,
  input  wire logic [acp_pkg::PORT_W-1:0] extEn,
  output logic      [acp_pkg::PORT_W-1:0] pinIn
);
  import acp_pkg::*;
  logic [PORT_W-1:0] wander = 8'h55;

  // Open lines toggle, so a stale level is never mistaken for a pin
  always_ff @(posedge clk) begin
    wander <= ~wander;
  end

  // Port drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!pinOe_n[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extDrv[i];
      else if (pullupOn[i]) pinIn[i] = 1'b1;
      else pinIn[i] = wander[i];
    end
  end
endmodule

// file: dv/acp_port_tb_top.sv
// Self-checking bench for the address-capable I/O port
`timescale 1ns/1ns
module acp_port_tb_top;
  import acp_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = 18'h0;
  logic [ADDR_W-1:0] araddr = 18'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [MODE_W-1:0] modePins = 3'h3;
  logic              hwStandbyPin = 1'b0, swStandby = 1'b0;
  logic [PORT_W-1:0] extAddr = 8'h0, extDrv = 8'h0, extEn = 8'h0;
  logic [PORT_W-1:0] pinIn, pinOut, pinOe_n, pullupOn;
  int                n_errors = 0;
  int                checked = 0;

  always #25 clk = ~clk;

  acp_port dut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .modePins(modePins), .hwStandbyPin(hwStandbyPin), .swStandby(swStandby),
    .extAddr(extAddr), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pullupOn(pullupOn));

  acp_pin_model u_pins (.clk(clk), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pullupOn(pullupOn), .extDrv(extDrv), .extEn(extEn), .pinIn(pinIn));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkp(input string what, input logic [7:0] exp, input logic [7:0] got);
    chk(what, {24'h0, exp}, {24'h0, got});
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Response ready comes late on purpose, so the stall path is exercised
  task automatic axw(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    chk("rdata", {24'h0, ed}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  // Mode is only caught after a power-on reset
  task automatic rst(input logic [2:0] m);
    @(posedge clk);
    arst_n <= 1'b0;
    modePins <= m;
    extEn <= 8'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_vals;
    rst(3'h3);
    chkp("oe_n", 8'hFF, pinOe_n);
    chkp("pull", 8'h00, pullupOn);
    extEn <= 8'hFF;
    extDrv <= 8'hC3;
    axr(IDX_OUTPUT_DATA, 8'h00, RESP_OKAY);
    axr(IDX_PULLUP_CONTROL, 8'h00, RESP_OKAY);
    axr(IDX_PIN_DIRECTION, DIRECTION_READBACK, RESP_OKAY);
    axr(IDX_PIN_STATE_VIEW, 8'hC3, RESP_OKAY);
    axw(16'h0123, 8'hFF, RESP_SLVERR);
    axr(16'h0123, 8'h00, RESP_SLVERR);
  endtask

  task automatic t_gpio(input logic [2:0] m);
    rst(m);
    extEn <= 8'h5A;
    extDrv <= 8'h96;
    axw(IDX_PIN_DIRECTION, 8'hA5, RESP_OKAY);
    axw(IDX_OUTPUT_DATA, 8'h3C, RESP_OKAY);
    axw(IDX_PULLUP_CONTROL, 8'hFF, RESP_OKAY);
    axw(IDX_PIN_STATE_VIEW, 8'hFF, RESP_OKAY);
    repeat (8) @(posedge clk);
    chkp("oe_n", 8'h5A, pinOe_n);
    chkp("drive", 8'h24, pinOut & 8'hA5);
    chkp("pull", 8'h5A, pullupOn);
    axr(IDX_PIN_STATE_VIEW, 8'h36, RESP_OKAY);
    axr(IDX_PULLUP_CONTROL, 8'hFF, RESP_OKAY);
    extEn <= 8'h00;
    axw(IDX_PIN_DIRECTION, 8'hFF, RESP_OKAY);
    repeat (8) @(posedge clk);
    chkp("drive", 8'h3C, pinOut);
    chkp("pull", 8'h00, pullupOn);
    axr(IDX_PIN_STATE_VIEW, 8'h3C, RESP_OKAY);
  endtask

  task automatic t_addr_all(input logic [2:0] m);
    rst(m);
    extAddr <= 8'h96;
    axw(IDX_PULLUP_CONTROL, 8'hFF, RESP_OKAY);
    axw(IDX_PIN_DIRECTION, 8'h00, RESP_OKAY);
    repeat (8) @(posedge clk);
    chkp("oe_n", 8'h00, pinOe_n);
    chkp("addr", 8'h96, pinOut);
    chkp("pull", 8'h00, pullupOn);
    extAddr <= 8'h69;
    repeat (4) @(posedge clk);
    chkp("addr", 8'h69, pinOut);
    axr(IDX_MODE_STATUS, {5'h0, m}, RESP_OKAY);
  endtask

  task automatic t_addr_sel(input logic [2:0] m);
    rst(m);
    extEn <= 8'h0F;
    extDrv <= 8'h0A;
    extAddr <= 8'hC3;
    axw(IDX_PIN_DIRECTION, 8'hF0, RESP_OKAY);
    axw(IDX_PULLUP_CONTROL, 8'hFF, RESP_OKAY);
    axw(IDX_OUTPUT_DATA, 8'h55, RESP_OKAY);
    repeat (8) @(posedge clk);
    chkp("oe_n", 8'h0F, pinOe_n);
    chkp("addr", 8'hC0, pinOut & 8'hF0);
    chkp("pull", 8'h0F, pullupOn);
    axr(IDX_PIN_STATE_VIEW, 8'h5A, RESP_OKAY);
  endtask

  task automatic t_hw_stby;
    rst(3'h3);
    axw(IDX_PIN_DIRECTION, 8'h0F, RESP_OKAY);
    axw(IDX_OUTPUT_DATA, 8'hFF, RESP_OKAY);
    axw(IDX_PULLUP_CONTROL, 8'hF0, RESP_OKAY);
    extEn <= 8'hFF;
    extDrv <= 8'hA5;
    hwStandbyPin <= 1'b1;
    repeat (12) @(posedge clk);
    chkp("oe_n", 8'hFF, pinOe_n);
    chkp("pull", 8'h00, pullupOn);
    hwStandbyPin <= 1'b0;
    repeat (8) @(posedge clk);
    axr(IDX_OUTPUT_DATA, 8'h00, RESP_OKAY);
    axr(IDX_PULLUP_CONTROL, 8'h00, RESP_OKAY);
    axr(IDX_PIN_STATE_VIEW, 8'hA5, RESP_OKAY);
  endtask

  // Software standby keeps registers; address pins hold or float
  task automatic t_sw_stby(input logic oe);
    rst(3'h1);
    extAddr <= 8'h5A;
    axw(IDX_STANDBY_CTRL, {7'h0, oe}, RESP_OKAY);
    axw(IDX_OUTPUT_DATA, 8'h33, RESP_OKAY);
    swStandby <= 1'b1;
    repeat (4) @(posedge clk);
    extAddr <= 8'hA5;
    repeat (4) @(posedge clk);
    chkp("oe_n", oe ? 8'h00 : 8'hFF, pinOe_n);
    if (oe) chkp("hold", 8'h5A, pinOut);
    axr(IDX_PIN_STATE_VIEW, 8'h5A, RESP_OKAY);
    axr(IDX_STANDBY_CTRL, {7'h0, oe}, RESP_OKAY);
    swStandby <= 1'b0;
    repeat (4) @(posedge clk);
    chkp("addr", 8'hA5, pinOut);
    axr(IDX_OUTPUT_DATA, 8'h33, RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    t_reset_vals();
    t_gpio(3'h3);
    t_gpio(3'h7);
    t_addr_all(3'h1);
    t_addr_all(3'h4);
    t_addr_all(3'h5);
    t_addr_sel(3'h2);
    t_addr_sel(3'h6);
    t_hw_stby();
    t_sw_stby(1'b1);
    t_sw_stby(1'b0);
    print_verdict();
  end

  // Whole run needs well under a thousand cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
